/* orp_pkg.sv */
package orp_pkg;
  localparam int ORP_CLK_MHZ       = 40;
  localparam int ORP_PULSE_US      = 100;
  localparam int ORP_PULSE_CYC     = ORP_PULSE_US * ORP_CLK_MHZ;
  localparam int ORP_SETUP_US      = 2;
  localparam int ORP_SETUP_CYC     = ORP_SETUP_US * ORP_CLK_MHZ;
  localparam int ORP_READ_NS       = 150;
  localparam int ORP_READ_CYC      = (ORP_READ_NS * ORP_CLK_MHZ + 999) / 1000;
  localparam int ORP_MAX_RETRY     = 10;
  localparam logic [1:0] ORP_SUP_READ = 2'h0;
  localparam logic [1:0] ORP_SUP_PROG = 2'h1;
  localparam logic [1:0] ORP_SUP_VERI = 2'h2;

  typedef enum logic [3:0] {
    ORP_IDLE  = 4'h0,
    ORP_RAMP  = 4'h1,
    ORP_P1SET = 4'h3,
    ORP_P1PUL = 4'h2,
    ORP_VSET  = 4'h6,
    ORP_VCHK  = 4'h7,
    ORP_VPUL  = 4'h5,
    ORP_LOWER = 4'h4,
    ORP_RSET  = 4'hC,
    ORP_RCHK  = 4'hD,
    ORP_DONE  = 4'hF,
    ORP_IDSET = 4'h8,
    ORP_IDCHK = 4'h9
  } orp_state_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic id_hv;
    logic [1:0] supply;
  } orp_ctl_t;
endpackage

/* orp_rom_model.sv */
`timescale 1ns/100ps
module orp_rom_model
  import orp_pkg::*;
#(
  parameter int         AW    = 3,
  // Arbitrary id values
  parameter logic [7:0] MAKER = 8'h3C,
  parameter logic [7:0] KIND  = 8'hC3
)(
  input  wire logic          wipe,
  input  wire orp_ctl_t      ctl,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    din,
  input  wire logic [AW-1:0] weak_addr,
  input  wire logic [4:0]    weak_need,
  output logic      [7:0]    dout
);
  logic [7:0] mem [2**AW];
  logic [7:0] last = 8'h55;
  int         hits;
  logic [AW-1:0] burn_addr;
  logic [7:0]    burn_din;
  logic          armed = 1'b0;
  always @(posedge wipe) begin
    foreach (mem[i]) mem[i] = 8'hFF;
    hits = 0;
  end
  // Pulse start latches address, data and mode once pins settle
  always @(negedge ctl.ce_n) begin
    #1;
    armed     = ctl.oe_n && ctl.supply == ORP_SUP_PROG;
    burn_addr = addr;
    burn_din  = din;
  end
  always @(posedge ctl.ce_n) begin
    if (armed) begin
      if (burn_addr == weak_addr) hits++;
      if (burn_addr != weak_addr || hits >= weak_need)
        mem[burn_addr] &= burn_din;
    end
    armed = 1'b0;
  end
  always @(dout) if (!ctl.ce_n && !ctl.oe_n) last = dout;
  always_comb begin
    if (!ctl.ce_n && !ctl.oe_n)
      dout = !ctl.id_hv ? mem[addr] : (addr[0] ? KIND : MAKER);
    else
      dout = ~last;
  end
endmodule

/* orp_sequencer.sv */
`timescale 1ns/100ps
module orp_sequencer
  import orp_pkg::*;
#(
  parameter int AW        = 19,
  parameter int PULSE_CYC = ORP_PULSE_CYC
)(
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          start,
  input  wire logic          id_start,
  output logic     [AW-1:0]  src_addr,
  input  wire logic [7:0]    src_data,
  output logic     [AW-1:0]  rom_addr,
  output logic     [7:0]     rom_dq_out,
  output logic               rom_dq_oe,
  input  wire logic [7:0]    rom_dq_in,
  output orp_ctl_t           rom_ctl,
  output logic               busy,
  output logic               done,
  output logic               pass,
  output logic     [15:0]    id_code
);
  orp_state_t state;
  logic [7:0]  dq_s1;
  logic [7:0]  dq_s2;
  logic [31:0] cnt;
  logic [3:0]  retry;
  logic        last;
  logic        fail;
  logic [AW-1:0] top_addr;

  assign top_addr = {AW{1'b1}};
  assign last     = (rom_addr == top_addr);

  always_ff @(posedge core_clk) begin
    dq_s1 <= rom_dq_in;
    dq_s2 <= dq_s1;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state      <= ORP_IDLE;
      cnt        <= '0;
      retry      <= '0;
      fail       <= 1'b0;
      rom_addr   <= '0;
      src_addr   <= '0;
      rom_dq_out <= 8'h00;
      rom_dq_oe  <= 1'b0;
      rom_ctl    <= '{ce_n: 1'b1, oe_n: 1'b1, id_hv: 1'b0,
                      supply: ORP_SUP_READ};
      busy       <= 1'b0;
      done       <= 1'b0;
      pass       <= 1'b0;
      id_code    <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (cnt != 0)
        cnt <= cnt - 32'd1;
      case (state)
        ORP_IDLE: begin
          if (start) begin
            rom_addr       <= '0;
            src_addr       <= '0;
            fail           <= 1'b0;
            busy           <= 1'b1;
            rom_ctl.supply <= ORP_SUP_PROG;
            cnt            <= ORP_SETUP_CYC;
            state          <= ORP_RAMP;
          end else if (id_start) begin
            busy          <= 1'b1;
            rom_addr      <= '0;
            rom_ctl.id_hv <= 1'b1;
            rom_ctl.oe_n  <= 1'b0;
            rom_ctl.ce_n  <= 1'b0;
            cnt           <= ORP_SETUP_CYC;
            state         <= ORP_IDSET;
          end
        end
        ORP_IDSET: if (cnt == 0) begin
          cnt   <= ORP_READ_CYC + 2;
          state <= ORP_IDCHK;
        end
        ORP_IDCHK: if (cnt == 0) begin
          if (!rom_addr[0]) begin
            id_code[15:8] <= dq_s2;
            rom_addr[0]   <= 1'b1;
            state         <= ORP_IDSET;
            cnt           <= ORP_SETUP_CYC;
          end else begin
            id_code[7:0]  <= dq_s2;
            rom_ctl       <= '{ce_n: 1'b1, oe_n: 1'b1, id_hv: 1'b0,
                               supply: ORP_SUP_READ};
            busy          <= 1'b0;
            done          <= 1'b1;
            pass          <= 1'b1;
            state         <= ORP_IDLE;
          end
        end
        ORP_RAMP: if (cnt == 0) begin
          rom_dq_out <= src_data;
          rom_dq_oe  <= 1'b1;
          cnt        <= ORP_SETUP_CYC;
          state      <= ORP_P1SET;
        end
        ORP_P1SET: if (cnt == 0) begin
          rom_ctl.ce_n <= 1'b0;
          cnt          <= PULSE_CYC - 1;
          state        <= ORP_P1PUL;
        end
        ORP_P1PUL: if (cnt == 0) begin
          rom_ctl.ce_n <= 1'b1;
          if (last) begin
            rom_addr <= '0;
            src_addr <= '0;
            // Data held until verify
            cnt      <= ORP_SETUP_CYC;
            retry    <= '0;
            state    <= ORP_VSET;
          end else begin
            rom_addr <= rom_addr + 1'b1;
            src_addr <= src_addr + 1'b1;
            cnt      <= ORP_SETUP_CYC;
            state    <= ORP_RAMP;
          end
        end
        ORP_VSET: if (cnt == 0) begin
          rom_dq_oe    <= 1'b0;
          rom_ctl.oe_n <= 1'b0;
          rom_ctl.ce_n <= 1'b0;
          cnt          <= ORP_READ_CYC + 2;
          state        <= ORP_VCHK;
        end
        ORP_VCHK: if (cnt == 0) begin
          rom_ctl.oe_n <= 1'b1;
          rom_ctl.ce_n <= 1'b1;
          if (dq_s2 == src_data) begin
            retry <= '0;
            cnt   <= ORP_SETUP_CYC;
            if (last) begin
              rom_ctl.supply <= ORP_SUP_VERI;
              state          <= ORP_LOWER;
            end else begin
              rom_addr <= rom_addr + 1'b1;
              src_addr <= src_addr + 1'b1;
              state    <= ORP_VSET;
            end
          end else if (retry == 4'(ORP_MAX_RETRY)) begin
            fail           <= 1'b1;
            rom_ctl.supply <= ORP_SUP_VERI;
            cnt            <= ORP_SETUP_CYC;
            state          <= ORP_LOWER;
          end else begin
            retry      <= retry + 4'h1;
            rom_dq_out <= src_data;
            rom_dq_oe  <= 1'b1;
            cnt        <= ORP_SETUP_CYC;
            state      <= ORP_VPUL;
          end
        end
        ORP_VPUL: begin
          if (cnt == 0 && rom_ctl.ce_n) begin
            rom_ctl.ce_n <= 1'b0;
            cnt          <= PULSE_CYC - 1;
          end else if (cnt == 0) begin
            rom_ctl.ce_n <= 1'b1;
            // Data held until verify
            cnt          <= ORP_SETUP_CYC;
            state        <= ORP_VSET;
          end
        end
        ORP_LOWER: if (cnt == 0) begin
          rom_addr <= '0;
          src_addr <= '0;
          cnt      <= ORP_SETUP_CYC;
          state    <= fail ? ORP_DONE : ORP_RSET;
        end
        ORP_RSET: if (cnt == 0) begin
          rom_ctl.oe_n <= 1'b0;
          rom_ctl.ce_n <= 1'b0;
          cnt          <= ORP_READ_CYC + 2;
          state        <= ORP_RCHK;
        end
        ORP_RCHK: if (cnt == 0) begin
          rom_ctl.oe_n <= 1'b1;
          rom_ctl.ce_n <= 1'b1;
          if (dq_s2 != src_data)
            fail <= 1'b1;
          cnt <= ORP_SETUP_CYC;
          if (last) begin
            state <= ORP_DONE;
          end else begin
            rom_addr <= rom_addr + 1'b1;
            src_addr <= src_addr + 1'b1;
            state    <= ORP_RSET;
          end
        end
        ORP_DONE: if (cnt == 0) begin
          rom_ctl.supply <= ORP_SUP_READ;
          busy           <= 1'b0;
          done           <= 1'b1;
          pass           <= ~fail;
          state          <= ORP_IDLE;
        end
        default: state <= ORP_IDLE;
      endcase
    end
  end
endmodule

/* orp_sequencer_bench.sv */
`timescale 1ns/100ps
module orp_sequencer_bench;
  import orp_pkg::*;
  logic           core_clk = 1'b0, sys_rst = 1'b1, start = 1'b0;
  logic           id_start = 1'b0, wipe = 1'b0, rom_dq_oe, busy, done;
  logic           pass, saw_low, burn_q = 1'b0;
  logic [2:0]     src_addr, rom_addr, weak_addr = 3'h0;
  logic [4:0]     weak_need = 5'h01;
  logic [7:0]     src_data, rom_dq_out, rom_dq_in, model_q;
  logic [15:0]    id_code;
  orp_ctl_t       rom_ctl;
  int             errors = 0, n_compared = 0, pulses = 0;
  always #12.5 core_clk = ~core_clk;
  assign src_data = 8'h5A ^ 8'(src_addr);
  assign rom_dq_in = rom_dq_oe ? rom_dq_out : model_q;
  always @(posedge core_clk) begin
    if (!rom_ctl.ce_n && rom_ctl.oe_n && !burn_q) pulses++;
    burn_q = !rom_ctl.ce_n && rom_ctl.oe_n;
  end
  always @(posedge core_clk) if (rom_ctl.supply == ORP_SUP_VERI) saw_low = 1;
  orp_sequencer #(.AW(3), .PULSE_CYC(10)) dut_u (.core_clk(core_clk),
    .sys_rst(sys_rst), .start(start), .id_start(id_start),
    .src_addr(src_addr), .src_data(src_data), .rom_addr(rom_addr),
    .rom_dq_out(rom_dq_out), .rom_dq_oe(rom_dq_oe), .rom_dq_in(rom_dq_in),
    .rom_ctl(rom_ctl), .busy(busy), .done(done), .pass(pass),
    .id_code(id_code));
  orp_rom_model #(.AW(3), .MAKER(8'h3C), .KIND(8'hC3)) rom_u (.wipe(wipe),
    .ctl(rom_ctl), .addr(rom_addr), .din(rom_dq_out),
    .weak_addr(weak_addr), .weak_need(weak_need), .dout(model_q));
  task automatic check(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      errors++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask
  task automatic wait_done();
    @(negedge core_clk);
    check(busy === 1'b1, "not busy");
    for (int t = 0; t < 15000 && done !== 1'b1; t++) @(negedge core_clk);
    check(done === 1'b1, "no done");
    check(busy === 1'b0, "busy after done");
  endtask
  task automatic run(input logic [2:0] wa, input logic [4:0] need,
                     input int npulse, input logic good);
    @(posedge core_clk);
    weak_addr <= wa;
    weak_need <= need;
    wipe <= 1'b1;
    start <= 1'b1;
    pulses = 0;
    saw_low = 0;
    @(posedge core_clk);
    wipe <= 1'b0;
    start <= 1'b0;
    wait_done();
    check(pass === good, "verdict");
    check(pulses == npulse, "pulse count");
    check(!good || saw_low, "supply not lowered");
  endtask
  task automatic id_read();
    @(posedge core_clk);
    id_start <= 1'b1;
    @(posedge core_clk);
    id_start <= 1'b0;
    wait_done();
    check(id_code === 16'h3CC3, "id code");
  endtask
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #1500000;
    errors++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    run(3'h0, 5'h01, 8, 1'b1);
    run(3'h5, 5'h04, 11, 1'b1);
    run(3'h2, 5'h0C, 18, 1'b0);
    id_read();
    conclude();
  end
endmodule

/* orp_sequencer_chk.sv */
`timescale 1ns/100ps
module orp_sequencer_chk
  import orp_pkg::*;
#(
  parameter int AW        = 19,
  parameter int PULSE_CYC = ORP_PULSE_CYC
)(
  input wire logic          core_clk,
  input wire logic          sys_rst,
  input wire logic [AW-1:0] rom_addr,
  input wire logic [7:0]    rom_dq_out,
  input wire logic          rom_dq_oe,
  input wire orp_ctl_t      rom_ctl,
  input wire logic          done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic burn;
  int   lo_cnt;
  int   tries;
  assign burn = !rom_ctl.ce_n && rom_ctl.oe_n;
  always_ff @(posedge core_clk) begin
    if (sys_rst || !burn) lo_cnt <= 0;
    else lo_cnt <= lo_cnt + 1;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst || $changed(rom_addr)) tries <= 0;
    else if ($rose(burn)) tries <= tries + 1;
  end
  property p_width; $fell(burn) && rom_ctl.ce_n |-> lo_cnt == PULSE_CYC;
  endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_hold;
    burn |-> $stable(rom_addr) && $stable(rom_dq_out) && rom_dq_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("pulse data moved");
  property p_supply; burn |-> rom_ctl.supply == ORP_SUP_PROG; endproperty
  a_supply: assert property (p_supply) else $error("pulse supply");
  property p_gate; !rom_ctl.oe_n |-> !rom_dq_oe; endproperty
  a_gate: assert property (p_gate) else $error("data clash");
  property p_tries; $rose(burn) |-> tries < ORP_MAX_RETRY; endproperty
  a_tries: assert property (p_tries) else $error("too many pulses");
  property p_done; done |=> !done; endproperty
  a_done: assert property (p_done) else $error("done too long");
  property p_step; $changed(rom_addr) && !rom_ctl.id_hv |->
    rom_addr == $past(rom_addr) + 1'b1 || rom_addr == '0; endproperty
  a_step: assert property (p_step) else $error("address order");
  property p_id; rom_ctl.id_hv && !rom_ctl.oe_n |-> rom_addr[AW-1:1] == '0;
  endproperty
  a_id: assert property (p_id) else $error("id address");
  c_retry: cover property ($rose(burn) && tries > 1);
  c_done: cover property (done);
  c_id: cover property (rom_ctl.id_hv);
endmodule
bind orp_sequencer orp_sequencer_chk #(.AW(AW), .PULSE_CYC(PULSE_CYC)) chk_u
  (.core_clk(core_clk), .sys_rst(sys_rst), .rom_addr(rom_addr),
   .rom_dq_out(rom_dq_out), .rom_dq_oe(rom_dq_oe), .rom_ctl(rom_ctl),
   .done(done));
